// file: include/phs_pkg.sv
package phs_pkg;
    localparam int unsigned VEC_W = 128;
    localparam int unsigned HALF_W = 64;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned DWORD_W = 32;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned N_WORD = VEC_W / WORD_W;
    localparam int unsigned N_DWORD = VEC_W / DWORD_W;
    localparam int unsigned N_BYTE = VEC_W / BYTE_W;
    localparam logic [15:0] SAT_MAX = 16'h7FFF;
    localparam logic [15:0] SAT_MIN = 16'h8000;
    localparam logic [127:0] ZERO_VEC = 128'h0;

    typedef enum logic [3:0] {
        OP_HORIZ_ADD_WORD,
        OP_HORIZ_ADD_WORD_SAT,
        OP_HORIZ_ADD_DWORD,
        OP_HORIZ_SUB_WORD,
        OP_HORIZ_SUB_WORD_SAT,
        OP_HORIZ_SUB_DWORD,
        OP_ABS_BYTE,
        OP_ABS_WORD,
        OP_ABS_DWORD,
        OP_MUL_ADD_UBYTE_SBYTE
    } phs_op_t;
endpackage

// file: rtl/phs_sat16.sv
`timescale 1ns/10ps
// Clamps a 17-bit signed value into the signed 16-bit range.
module phs_sat16 (
    input wire logic [16:0] val_i,
    output logic [15:0] res_o
);
    import phs_pkg::*;

    wire over = (val_i[16:15] == 2'b01);
    wire under = (val_i[16:15] == 2'b10);

    assign res_o = over ? SAT_MAX : (under ? SAT_MIN : val_i[15:0]);
endmodule

// file: rtl/phs_simd_alu.sv
`timescale 1ns/10ps
module phs_simd_alu (
    input wire logic CLOCK_I,
    input wire logic NRST_I,
    input wire logic VALID_I,
    input wire logic WIDE_I,
    input wire phs_pkg::phs_op_t OP_I,
    input wire logic [127:0] DST_I,
    input wire logic [127:0] SRC_I,
    output logic VALID_O,
    output logic [127:0] RESULT_O
);
    import phs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Operand narrowing: in 64-bit mode only the low halves take part.
    wire [127:0] dst = WIDE_I ? DST_I : {HALF_W'(0), DST_I[63:0]};
    wire [127:0] src = WIDE_I ? SRC_I : {HALF_W'(0), SRC_I[63:0]};

    // The horizontal ops see the concatenation of the live parts.
    // Destination pairs come first so they land in the low result half.
    wire [255:0] cat_w = WIDE_I ? {src, dst} : {128'h0, src[63:0], dst[63:0]};

    ////////////////////////////////////////////////////////////////////////
    // Per-lane results: horizontal word and dword, absolute value, multiply-add.
    logic [127:0] hadd_w, hadds_w, hsub_w, hsubs_w;
    logic [127:0] hadd_d, hsub_d;
    logic [127:0] abs_b, abs_w, abs_d, madd;

    genvar g;
    generate
        for (g = 0; g < N_WORD; g++) begin : g_word
            wire [15:0] lo = cat_w[32*g +: 16];
            wire [15:0] hi = cat_w[32*g+16 +: 16];
            wire [16:0] s17 = {lo[15], lo} + {hi[15], hi};
            wire [16:0] d17 = {lo[15], lo} - {hi[15], hi};
            wire [15:0] s_sat;
            wire [15:0] d_sat;
            phs_sat16 u_sat_add (.val_i(s17), .res_o(s_sat));
            phs_sat16 u_sat_sub (.val_i(d17), .res_o(d_sat));
            assign hadd_w[16*g +: 16] = lo + hi;
            assign hadds_w[16*g +: 16] = s_sat;
            assign hsub_w[16*g +: 16] = lo - hi;
            assign hsubs_w[16*g +: 16] = d_sat;
        end
        for (g = 0; g < N_DWORD; g++) begin : g_dword
            wire [31:0] lo = cat_w[64*g +: 32];
            wire [31:0] hi = cat_w[64*g+32 +: 32];
            assign hadd_d[32*g +: 32] = lo + hi;
            assign hsub_d[32*g +: 32] = lo - hi;
        end
        // Negating in the element width gives 2^(w-1) for the most negative
        // value, which read as unsigned is the correct magnitude.
        for (g = 0; g < N_BYTE; g++) begin : g_abs_b
            wire [7:0] e = src[8*g +: 8];
            assign abs_b[8*g +: 8] = e[7] ? 8'(-e) : e;
        end
        for (g = 0; g < N_WORD; g++) begin : g_abs_w
            wire [15:0] e = src[16*g +: 16];
            assign abs_w[16*g +: 16] = e[15] ? 16'(-e) : e;
        end
        for (g = 0; g < N_DWORD; g++) begin : g_abs_d
            wire [31:0] e = src[32*g +: 32];
            assign abs_d[32*g +: 32] = e[31] ? 32'(-e) : e;
        end
        for (g = 0; g < N_WORD; g++) begin : g_madd
            wire signed [16:0] p0 = $signed({1'b0, dst[16*g +: 8]}) *
                                    $signed(src[16*g +: 8]);
            wire signed [16:0] p1 = $signed({1'b0, dst[16*g+8 +: 8]}) *
                                    $signed(src[16*g+8 +: 8]);
            wire signed [17:0] sum = 18'(p0) + 18'(p1);
            wire over = (sum > 18'sh07FFF);
            wire under = (sum < -18'sh08000);
            assign madd[16*g +: 16] = over ? SAT_MAX :
                                      (under ? SAT_MIN : sum[15:0]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Result selection.
    logic [127:0] sel;
    always_comb begin
        case (OP_I)
            OP_HORIZ_ADD_WORD: sel = hadd_w;
            OP_HORIZ_ADD_WORD_SAT: sel = hadds_w;
            OP_HORIZ_ADD_DWORD: sel = hadd_d;
            OP_HORIZ_SUB_WORD: sel = hsub_w;
            OP_HORIZ_SUB_WORD_SAT: sel = hsubs_w;
            OP_HORIZ_SUB_DWORD: sel = hsub_d;
            OP_ABS_BYTE: sel = abs_b;
            OP_ABS_WORD: sel = abs_w;
            OP_ABS_DWORD: sel = abs_d;
            OP_MUL_ADD_UBYTE_SBYTE: sel = madd;
            default: sel = ZERO_VEC;
        endcase
    end

    // Upper half is zero in 64-bit mode.
    wire [127:0] result_d = WIDE_I ? sel : {HALF_W'(0), sel[63:0]};

    ////////////////////////////////////////////////////////////////////////
    // One-stage output register.
    logic valid_q;
    logic [127:0] result_q;

    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            valid_q <= 1'b0;
            result_q <= ZERO_VEC;
        end else begin
            valid_q <= VALID_I;
            if (VALID_I) begin
                result_q <= result_d;
            end
        end
    end

    assign VALID_O = valid_q;
    assign RESULT_O = result_q;
endmodule

// file: verif/phs_simd_alu_checker.sv
`timescale 1ns/10ps
module phs_simd_alu_checker (
    input wire logic CLOCK_I,
    input wire logic NRST_I,
    input wire logic VALID_I,
    input wire logic WIDE_I,
    input wire phs_pkg::phs_op_t OP_I,
    input wire logic [127:0] DST_I,
    input wire logic [127:0] SRC_I,
    input wire logic VALID_O,
    input wire logic [127:0] RESULT_O
);
    import phs_pkg::*;
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!NRST_I);
    a_valid_follows: assert property (VALID_I |=> VALID_O) else $error("late");
    a_no_spurious: assert property (!VALID_I |=> !VALID_O) else $error("spurious");
    a_hold_result: assert property (!VALID_I |=> $stable(RESULT_O)) else $error("held");
    a_narrow_upper: assert property (VALID_I && !WIDE_I |=> RESULT_O[127:64] == 64'h0)
        else $error("upper");
    a_add_word_lane: assert property (VALID_I && OP_I == OP_HORIZ_ADD_WORD |=>
        RESULT_O[15:0] == $past(DST_I[15:0] + DST_I[31:16])) else $error("add");
    a_add_dword_lane: assert property (VALID_I && OP_I == OP_HORIZ_ADD_DWORD |=>
        RESULT_O[31:0] == $past(DST_I[31:0] + DST_I[63:32])) else $error("addd");
    a_sub_word_lane: assert property (VALID_I && OP_I == OP_HORIZ_SUB_WORD |=>
        RESULT_O[15:0] == $past(DST_I[15:0] - DST_I[31:16])) else $error("sub");
    a_abs_byte_lane: assert property (VALID_I && OP_I == OP_ABS_BYTE |=> RESULT_O[7:0] ==
        $past(SRC_I[7] ? 8'h0 - SRC_I[7:0] : SRC_I[7:0])) else $error("abs");
endmodule
bind phs_simd_alu phs_simd_alu_checker u_chk (.CLOCK_I, .NRST_I, .VALID_I, .WIDE_I, .OP_I,
    .DST_I, .SRC_I, .VALID_O, .RESULT_O);

// file: verif/phs_host_model.sv
`timescale 1ns/10ps
module phs_host_model (
    input wire logic CLOCK_I,
    output logic VALID_O = 1'h0,
    output logic WIDE_O = 1'h0,
    output phs_pkg::phs_op_t OP_O = phs_pkg::OP_ABS_BYTE,
    output logic [127:0] DST_O = 128'h0,
    output logic [127:0] SRC_O = 128'h0
);
    import phs_pkg::*;
    task automatic issue(input phs_op_t o, input logic w, input logic [127:0] d, s);
        @(posedge CLOCK_I);
        VALID_O <= 1'h1;
        WIDE_O <= w;
        OP_O <= o;
        DST_O <= d;
        SRC_O <= s;
        @(posedge CLOCK_I);
        // Released operands show the inverse so stale data cannot pass.
        VALID_O <= 1'h0;
        DST_O <= ~d;
        SRC_O <= ~s;
    endtask
endmodule

// file: verif/packed_int_horiz_simd_alu_tb.sv
`timescale 1ns/10ps
module packed_int_horiz_simd_alu_tb;
    import phs_pkg::*;
    localparam logic [127:0] DA = 128'h00080007000600050004000300020001;
    localparam logic [127:0] SA = 128'h7FFF0001FFFF00010010002080008000;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic vld, wide, vld_o;
    phs_op_t op;
    logic [127:0] dst, src, res;
    int error_cnt = 0;
    int checks = 0;
    phs_host_model u_host (.CLOCK_I(clk), .VALID_O(vld), .WIDE_O(wide), .OP_O(op),
        .DST_O(dst), .SRC_O(src));
    phs_simd_alu u_dut (.CLOCK_I(clk), .NRST_I(rst_n), .VALID_I(vld), .WIDE_I(wide),
        .OP_I(op), .DST_I(dst), .SRC_I(src), .VALID_O(vld_o), .RESULT_O(res));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic run(input phs_op_t o, input logic w, input logic [127:0] d, s, e);
        u_host.issue(o, w, d, s);
        #1;
        checks++;
        if (res !== e || vld_o !== 1'h1) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, res, e);
        end
    endtask
    task automatic t_horiz;
        run(OP_HORIZ_ADD_WORD, 1'h1, DA, SA, 128'h8000000000300000000F000B00070003);
        run(OP_HORIZ_ADD_WORD_SAT, 1'h1, DA, SA, 128'h7FFF000000308000000F000B00070003);
        run(OP_HORIZ_ADD_DWORD, 1'h1, DA, SA, 128'h7FFE000280108020000E000C00060004);
        run(OP_HORIZ_SUB_WORD, 1'h1, DA, SA, 128'h8002000200100000FFFFFFFFFFFFFFFF);
        run(OP_HORIZ_SUB_WORD_SAT, 1'h0, DA, 128'h123456789ABCDEF080017FFF00018000,
            128'h7FFF8000FFFFFFFF);
        run(OP_HORIZ_SUB_DWORD, 1'h1, DA, SA, 128'h800000007FF07FE0FFFDFFFEFFFDFFFE);
    endtask
    task automatic t_abs_madd;
        run(OP_ABS_BYTE, 1'h1, DA, 128'h807FFF01 << 96, 128'h807F0101 << 96);
        run(OP_ABS_WORD, 1'h1, DA, SA, 128'h7FFF0001000100010010002080008000);
        run(OP_ABS_DWORD, 1'h1, DA, SA, 128'h7FFF00010000FFFF001000207FFF8000);
        run(OP_MUL_ADD_UBYTE_SBYTE, 1'h0, 128'hFFFF0201FFFF0003,
            128'h1111000000000000808080807F7F05FE, 128'h8000FE807FFFFFFA);
    endtask
    task automatic end_sim;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        t_horiz();
        t_abs_madd();
        end_sim();
    end
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
endmodule
